// [logic/bmc_dev_end.sv]
`timescale 1ns/1ps
// ***********************************************************
// documented device end
// ***********************************************************
module bmc_dev_end
  import bmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  bmc_line_if.dev   line,
  input  wire logic line_sel,
  input  wire logic tx_en,
  input  wire logic tx_valid,
  output logic      tx_ready,
  input  wire logic tx_data,
  input  wire logic tx_last,
  output logic      tx_busy,
  output logic      rx_valid,
  output logic      rx_data,
  output logic      rx_active
);
  bmc_phy u_phy
  (
    .clk       (clk),
    .rst       (rst),
    .line_sel  (line_sel),
    .tx_en     (tx_en),
    .tx_valid  (tx_valid),
    .tx_ready  (tx_ready),
    .tx_data   (tx_data),
    .tx_last   (tx_last),
    .tx_busy   (tx_busy),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_active (rx_active),
    .line_a_o  (line.line_a_dev_o),
    .line_a_oe (line.line_a_dev_oe),
    .line_b_o  (line.line_b_dev_o),
    .line_b_oe (line.line_b_dev_oe),
    .line_a_i  (line.config_line_a),
    .line_b_i  (line.config_line_b)
  );
endmodule

// [logic/bmc_far_end.sv]
`timescale 1ns/1ps
// ***********************************************************
// far-end partner, sits on one line only
// ***********************************************************
module bmc_far_end
  import bmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  bmc_line_if.far   line,
  input  wire logic tx_en,
  input  wire logic tx_valid,
  output logic      tx_ready,
  input  wire logic tx_data,
  input  wire logic tx_last,
  output logic      tx_busy,
  output logic      rx_valid,
  output logic      rx_data,
  output logic      rx_active
);
  // selecting line b always; the a-side drive outputs are unused
  bmc_phy u_phy
  (
    .clk       (clk),
    .rst       (rst),
    .line_sel  (1'b1),
    .tx_en     (tx_en),
    .tx_valid  (tx_valid),
    .tx_ready  (tx_ready),
    .tx_data   (tx_data),
    .tx_last   (tx_last),
    .tx_busy   (tx_busy),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_active (rx_active),
    .line_a_o  (),
    .line_a_oe (),
    .line_b_o  (line.line_far_o),
    .line_b_oe (line.line_far_oe),
    .line_a_i  (1'b1),
    .line_b_i  (line.config_line_b)
  );
endmodule

// [logic/bmc_line_if.sv]
`timescale 1ns/1ps
// shared configuration-channel pair; wire level resolved from the enables
interface bmc_line_if;
  logic line_a_dev_o;
  logic line_a_dev_oe;
  logic line_b_dev_o;
  logic line_b_dev_oe;
  logic line_far_o;
  logic line_far_oe;
  logic config_line_a;
  logic config_line_b;
  // far end sits on the line that carries the bias; pulled high when released
  assign config_line_a = line_a_dev_oe ? line_a_dev_o : 1'b1;
  assign config_line_b = line_b_dev_oe ? line_b_dev_o :
                         (line_far_oe ? line_far_o : 1'b1);
  modport dev
  (
    output line_a_dev_o,
    output line_a_dev_oe,
    output line_b_dev_o,
    output line_b_dev_oe,
    input  config_line_a,
    input  config_line_b
  );
  modport far
  (
    output line_far_o,
    output line_far_oe,
    input  config_line_b
  );
endinterface

// [logic/bmc_phy.sv]
`timescale 1ns/1ps
// ***********************************************************
// coded line end, used by both parties
// ***********************************************************
module bmc_phy
  import bmc_pkg::*;
#(
  parameter int unsigned HALF_CYC = BMC_HALF_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line_sel,
  input  wire logic tx_en,
  input  wire logic tx_valid,
  output logic      tx_ready,
  input  wire logic tx_data,
  input  wire logic tx_last,
  output logic      tx_busy,
  output logic      rx_valid,
  output logic      rx_data,
  output logic      rx_active,
  output logic      line_a_o,
  output logic      line_a_oe,
  output logic      line_b_o,
  output logic      line_b_oe,
  input  wire logic line_a_i,
  input  wire logic line_b_i
);
  // ***********************************************************
  // transmitter
  // ***********************************************************
  bmc_tx_state_t        st_r, st_nxt;
  logic [BMC_CNT_W-1:0] tcnt_r, tcnt_nxt;
  logic                 lvl_r, lvl_nxt;
  logic                 half_r, half_nxt;
  logic                 bit_r, bit_nxt;
  logic                 last_r, last_nxt;
  logic                 tick;
  logic                 line_in;

  assign tick = (tcnt_r == BMC_CNT_W'(HALF_CYC - 1));

  // bit taken only when idle or at a cell boundary so cells never stretch
  assign tx_ready = tx_en && ((st_r == BMC_TX_IDLE) ||
                    (st_r == BMC_TX_CELL && tick && half_r && !last_r));
  assign tx_busy  = (st_r != BMC_TX_IDLE);

  // next state of the encoder
  always_comb
  begin
    st_nxt   = st_r;
    tcnt_nxt = tick ? '0 : tcnt_r + 1'b1;
    lvl_nxt  = lvl_r;
    half_nxt = half_r;
    bit_nxt  = bit_r;
    last_nxt = last_r;
    unique case (st_r)
      BMC_TX_IDLE:
      begin
        tcnt_nxt = '0;
        lvl_nxt  = BMC_IDLE_LVL;
        if (tx_valid && tx_ready)
        begin
          st_nxt   = BMC_TX_FIRST;
          bit_nxt  = tx_data;
          last_nxt = tx_last;
        end
      end
      BMC_TX_FIRST:
      begin
        // one half cell of low before the first coded edge
        if (tick)
        begin
          st_nxt   = BMC_TX_CELL;
          lvl_nxt  = ~lvl_r;
          half_nxt = 1'b0;
        end
      end
      BMC_TX_CELL:
      begin
        if (tick && !half_r)
        begin
          half_nxt = 1'b1;
          if (bit_r)
            lvl_nxt = ~lvl_r;
        end
        else if (tick)
        begin
          half_nxt = 1'b0;
          lvl_nxt  = ~lvl_r;
          if (last_r || !(tx_valid && tx_ready))
            st_nxt = BMC_TX_CLOSE;
          else
          begin
            bit_nxt  = tx_data;
            last_nxt = tx_last;
          end
        end
      end
      BMC_TX_CLOSE:
      begin
        // hold the closing level half a cell, then release
        if (tick)
          st_nxt = BMC_TX_IDLE;
      end
      default:
        st_nxt = BMC_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r   <= BMC_TX_IDLE;
      tcnt_r <= '0;
      lvl_r  <= BMC_IDLE_LVL;
      half_r <= 1'b0;
      bit_r  <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      tcnt_r <= tcnt_nxt;
      lvl_r  <= lvl_nxt;
      half_r <= half_nxt;
      bit_r  <= bit_nxt;
      last_r <= last_nxt;
    end
  end

  // ***********************************************************
  // line steering
  // ***********************************************************
  // release when idle
  always_comb
  begin
    line_a_o  = lvl_r;
    line_b_o  = lvl_r;
    line_a_oe = tx_busy && !line_sel;
    line_b_oe = tx_busy && line_sel;
    line_in   = line_sel ? line_b_i : line_a_i;
  end

  // ***********************************************************
  // receiver
  // ***********************************************************
  logic                 prev_r, prev_nxt;
  logic [BMC_CNT_W-1:0] gap_r, gap_nxt;
  logic                 lock_r, lock_nxt;
  logic                 mid_r, mid_nxt;
  logic                 sync_r, sync_nxt;
  logic                 rxv_r, rxv_nxt;
  logic                 rxd_r, rxd_nxt;
  logic                 edge_s;

  // own transmission is not decoded: only one party sends at a time
  assign edge_s = (line_in != prev_r) && !tx_busy;

  // next state of the decoder, measured between successive edges
  always_comb
  begin
    prev_nxt = line_in;
    gap_nxt  = (gap_r == '1) ? gap_r : gap_r + 1'b1;
    lock_nxt = lock_r;
    mid_nxt  = mid_r;
    sync_nxt = sync_r;
    rxv_nxt  = 1'b0;
    rxd_nxt  = rxd_r;
    if (edge_s)
    begin
      gap_nxt = '0;
      // any edge can start lock
      // a drop to the opening level starts the preamble, so the next edge opens the
      // first cell; a rise is that cell start itself, which covers a lost first edge
      if (!lock_r)
      begin
        lock_nxt = 1'b1;
        mid_nxt  = 1'b0;
        sync_nxt = (line_in == BMC_IDLE_LVL);
      end
      // first cell start after the opening low carries no bit
      else if (sync_r)
      begin
        sync_nxt = 1'b0;
        mid_nxt  = 1'b0;
      end
      // long gap zero, short pair one
      else if (gap_r >= BMC_CNT_W'(BMC_RX_THR_CYC))
      begin
        rxv_nxt = !mid_r;
        rxd_nxt = 1'b0;
        mid_nxt = 1'b0;
      end
      else if (mid_r)
      begin
        rxv_nxt = 1'b1;
        rxd_nxt = 1'b1;
        mid_nxt = 1'b0;
      end
      else
        mid_nxt = 1'b1;
    end
    else if (gap_r >= BMC_CNT_W'(BMC_RX_IDLE_CYC))
    begin
      lock_nxt = 1'b0;
      mid_nxt  = 1'b0;
      sync_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_r <= 1'b1;
      gap_r  <= '0;
      lock_r <= 1'b0;
      mid_r  <= 1'b0;
      sync_r <= 1'b0;
      rxv_r  <= 1'b0;
      rxd_r  <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      gap_r  <= gap_nxt;
      lock_r <= lock_nxt;
      mid_r  <= mid_nxt;
      sync_r <= sync_nxt;
      rxv_r  <= rxv_nxt;
      rxd_r  <= rxd_nxt;
    end
  end

  assign rx_valid  = rxv_r;
  assign rx_data   = rxd_r;
  assign rx_active = lock_r;
endmodule

// [logic/bmc_pkg.sv]
package bmc_pkg;
  // ***********************************************************
  // line timing
  // ***********************************************************
  // one unit interval in ns (300 kbit/s), and the core clock period in ns
  localparam int unsigned BMC_UI_NS       = 3336;
  localparam int unsigned BMC_CLK_NS      = 8;
  // half a unit interval in cycles, rounded down
  localparam int unsigned BMC_HALF_CYC    = BMC_UI_NS / (2 * BMC_CLK_NS);
  localparam int unsigned BMC_CNT_W       = 12;
  // receive gap at or above this many cycles is a full (zero) cell
  localparam int unsigned BMC_RX_THR_CYC  = (BMC_HALF_CYC * 3) / 2;
  // receive silence that ends a frame: four half cells
  localparam int unsigned BMC_RX_IDLE_CYC = BMC_HALF_CYC * 4;
  // idle level before the first coded edge
  localparam logic        BMC_IDLE_LVL    = 1'b0;

  typedef enum logic [3:0]
  {
    BMC_TX_IDLE  = 4'b0001,
    BMC_TX_FIRST = 4'b0010,
    BMC_TX_CELL  = 4'b0100,
    BMC_TX_CLOSE = 4'b1000
  } bmc_tx_state_t;
endpackage

// [test/bmc_line_asserts.sv]
`timescale 1ns/1ps
// ************
// line checker
// ************
module bmc_line_asserts
  import bmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic line_a_dev_o,
  input wire logic line_a_dev_oe,
  input wire logic line_b_dev_o,
  input wire logic line_b_dev_oe,
  input wire logic line_far_o,
  input wire logic line_far_oe,
  input wire logic config_line_a,
  input wire logic config_line_b
);
  localparam int H = BMC_HALF_CYC;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic        prev_r;
  // gap since last wire change; wraps in long idle, harmless as a frame opens with a change
  always_comb
  begin
    cnt_nxt = (rst || config_line_b != prev_r) ? 12'h000 : cnt_r + 12'h001;
  end
  always_ff @(posedge clk)
  begin
    prev_r <= config_line_b;
    cnt_r  <= cnt_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_b_low;
    !line_b_dev_o [*8];
  endsequence
  sequence s_far_low;
    !line_far_o [*8];
  endsequence
  a_one_sender: assert property (!(line_b_dev_oe && line_far_oe))
    else $error("two senders on line b");
  a_one_line: assert property (!(line_a_dev_oe && line_b_dev_oe))
    else $error("both lines driven");
  a_b_low_start: assert property ($rose(line_b_dev_oe) |-> s_b_low)
    else $error("line b frame not opened low");
  a_far_low_start: assert property ($rose(line_far_oe) |-> s_far_low)
    else $error("far frame not opened low");
  a_a_low_start: assert property ($rose(line_a_dev_oe) |-> !line_a_dev_o [*8])
    else $error("line a frame not opened low");
  a_cell_spacing: assert property ($changed(config_line_b)
    && $past(line_b_dev_oe || line_far_oe) && (line_b_dev_oe || line_far_oe)
    |-> cnt_r == H - 1 || cnt_r == 2 * H - 1)
    else $error("edge off the half cell grid");
  a_release_time: assert property ($fell(line_b_dev_oe) || $fell(line_far_oe)
    |-> cnt_r == H - 1)
    else $error("release not one half cell after closing edge");
  a_a_cell_hold: assert property (line_a_dev_oe && $changed(line_a_dev_o)
    |=> $stable(line_a_dev_o) [*8])
    else $error("line a level too short");
endmodule

// [test/bmc_line_tb.sv]
`timescale 1ns/1ps
module bmc_line_tb;
  logic       clk, rst, sel, en;
  logic       d_v, d_d, d_l, d_rdy, d_busy, d_rxv, d_rx, d_act;
  logic       f_v, f_d, f_l, f_rdy, f_busy, f_rxv, f_rx, f_act;
  logic [7:0] d_bits, f_bits;
  logic       b_low;
  int         d_n, f_n, failures, n_tests;
  // ************
  // structure
  // ************
  bmc_line_if bmc_line_if_inst ();
  bmc_dev_end bmc_dev_end_inst (.clk(clk), .rst(rst), .line(bmc_line_if_inst),
    .line_sel(sel), .tx_en(en), .tx_valid(d_v), .tx_ready(d_rdy), .tx_data(d_d),
    .tx_last(d_l), .tx_busy(d_busy), .rx_valid(d_rxv), .rx_data(d_rx), .rx_active(d_act));
  bmc_far_end bmc_far_end_inst (.clk(clk), .rst(rst), .line(bmc_line_if_inst),
    .tx_en(en), .tx_valid(f_v), .tx_ready(f_rdy), .tx_data(f_d),
    .tx_last(f_l), .tx_busy(f_busy), .rx_valid(f_rxv), .rx_data(f_rx), .rx_active(f_act));
  bmc_line_asserts bmc_line_asserts_inst (.clk(clk), .rst(rst),
    .line_a_dev_o(bmc_line_if_inst.line_a_dev_o), .line_a_dev_oe(bmc_line_if_inst.line_a_dev_oe),
    .line_b_dev_o(bmc_line_if_inst.line_b_dev_o), .line_b_dev_oe(bmc_line_if_inst.line_b_dev_oe),
    .line_far_o(bmc_line_if_inst.line_far_o), .line_far_oe(bmc_line_if_inst.line_far_oe),
    .config_line_a(bmc_line_if_inst.config_line_a),
    .config_line_b(bmc_line_if_inst.config_line_b));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // collect received bits, lsb first, and note any low on line b
  always @(posedge clk)
  begin
    if (d_rxv)
    begin
      d_bits[d_n[2:0]] <= d_rx;
      d_n <= d_n + 1;
    end
    if (f_rxv)
    begin
      f_bits[f_n[2:0]] <= f_rx;
      f_n <= f_n + 1;
    end
    if (!bmc_line_if_inst.config_line_b)
      b_low <= 1'b1;
  end
  // ************
  // helpers
  // ************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic clr();
    d_n = 0;
    f_n = 0;
    d_bits = 8'h00;
    f_bits = 8'h00;
    b_low = 1'b0;
  endtask
  // one frame of eight bits; waits for release, then a fixed 1000 cycles for receive lock to drop
  task automatic send(input logic far, input logic [7:0] b);
    int   i;
    logic r;
    for (i = 0; i < 8; i++)
    begin
      if (far)
        {f_v, f_d, f_l} = {1'b1, b[i], i == 7};
      else
        {d_v, d_d, d_l} = {1'b1, b[i], i == 7};
      do
      begin
        #1 r = far ? f_rdy : d_rdy;
        @(posedge clk);
      end while (!r);
      @(negedge clk);
      if (i == 0)
        chk((far || sel) ? bmc_line_if_inst.config_line_b : bmc_line_if_inst.config_line_a,
            1'b0, "frame not opened low");
    end
    d_v = 1'b0;
    f_v = 1'b0;
    for (i = 0; i < 3000 && (d_busy || f_busy); i++)
      @(negedge clk);
    repeat (1000) @(negedge clk);
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_idle();
    chk({d_busy, f_busy, bmc_line_if_inst.line_a_dev_oe, bmc_line_if_inst.line_b_dev_oe,
         bmc_line_if_inst.line_far_oe}, 8'h00, "driver not released");
    $display("done idle");
  endtask
  task automatic t_dev_to_far();
    clr();
    sel = 1'b1;
    send(1'b0, 8'hb2);
    chk(f_n[7:0], 8'h08, "far bit count");
    chk(f_bits, 8'hb2, "far bits");
    chk(d_n[7:0], 8'h00, "own frame heard");
    chk(f_act, 1'b0, "lock kept in silence");
    $display("done dev_to_far");
  endtask
  task automatic t_far_to_dev();
    clr();
    send(1'b1, 8'h4d);
    chk(d_n[7:0], 8'h08, "dev bit count");
    chk(d_bits, 8'h4d, "dev bits");
    chk({bmc_line_if_inst.config_line_b, d_busy}, 8'h02, "line b not idle high");
    chk(d_act, 1'b0, "dev lock kept in silence");
    $display("done far_to_dev");
  endtask
  task automatic t_line_a();
    clr();
    sel = 1'b0;
    send(1'b0, 8'h0f);
    chk(f_n[7:0], 8'h00, "traffic on unselected line");
    chk(b_low, 1'b0, "line b driven");
    $display("done line_a");
  endtask
  task automatic t_rx_sel();
    clr();
    send(1'b1, 8'h5a);
    chk(d_n[7:0], 8'h00, "unselected line received");
    $display("done rx_sel");
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst, sel, en, d_v, d_d, d_l, f_v, f_d, f_l} = 9'h1c0;
    failures = 0;
    n_tests = 0;
    clr();
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
    t_dev_to_far();
    t_far_to_dev();
    t_line_a();
    t_rx_sel();
    end_of_test();
  end
  // four frames need about 20k cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
